// ===== rtl/fsw_pkg.sv
// ****************************************************************
// Constants for the nonvolatile settings write command.
// ****************************************************************
package fsw_pkg;
  // Command and sub-codes of the settings write report.
  localparam logic [7:0] FSW_CMD_WRITE  = 8'hB1;
  localparam logic [7:0] FSW_SUB_CHIP   = 8'h00;
  localparam logic [7:0] FSW_SUB_PIN    = 8'h01;
  localparam logic [7:0] FSW_SUB_MFR    = 8'h02;
  localparam logic [7:0] FSW_SUB_SER    = 8'h04;
  localparam logic [7:0] FSW_STAT_OK    = 8'h00;
  localparam logic [7:0] FSW_STAT_UNSUP = 8'h01;
  // Byte positions inside the 64-byte report.
  localparam logic [5:0] FSW_IDX_SUB    = 6'h01;
  localparam logic [5:0] FSW_IDX_CHIP   = 6'h02;
  localparam logic [5:0] FSW_IDX_CLKDIV = 6'h03;
  localparam logic [5:0] FSW_IDX_DAC    = 6'h04;
  localparam logic [5:0] FSW_IDX_PIN_HI = 6'h05;
  localparam logic [5:0] FSW_IDX_PWD_LO = 6'h0C;
  localparam logic [5:0] FSW_IDX_PWD_HI = 6'h13;
  localparam logic [5:0] FSW_IDX_LAST   = 6'h3F;
  // Field positions in the packed chip settings word.
  localparam int FSW_B_SERIAL  = 7;
  localparam int FSW_B_RX_IDLE = 6;
  localparam int FSW_B_TX_IDLE = 5;
  localparam int FSW_B_TW_IDLE = 4;
  localparam int FSW_B_SP_IDLE = 3;
  localparam int FSW_B_CF_IDLE = 2;
  localparam int FSW_B_DIV_LSB = 8;
  localparam int FSW_B_DAC_SRC = 21;
  localparam int FSW_B_DREF    = 22;
  localparam int FSW_B_DAC_LSB = 16;
  // String storage, one 62-byte slot per descriptor.
  localparam int FSW_STR_LEN   = 62;
  localparam int FSW_STR_TOTAL = 186;
  // Reset values.
  localparam logic [23:0] FSW_CHIP_RST = 24'h000000;
  localparam logic [31:0] FSW_PIN_RST  = 32'h00000000;
  // Register byte offsets on the bus.
  localparam logic [7:0] FSW_A_STATUS   = 8'h00;
  localparam logic [7:0] FSW_A_CHIP     = 8'h04;
  localparam logic [7:0] FSW_A_PIN      = 8'h08;
  localparam logic [7:0] FSW_A_PWD_LO   = 8'h0C;
  localparam logic [7:0] FSW_A_PWD_HI   = 8'h10;
  localparam logic [7:0] FSW_A_STR_SEL  = 8'h14;
  localparam logic [7:0] FSW_A_STR_DATA = 8'h18;
  // Report parser states, Gray coded along idle, sub, data.
  typedef enum logic [1:0] {
    FSW_ST_IDLE = 2'b00,
    FSW_ST_SUB  = 2'b01,
    FSW_ST_DATA = 2'b11,
    FSW_ST_SKIP = 2'b10
  } fsw_state_t;
endpackage

// ===== rtl/fsw_settings_write.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module fsw_settings_write
  import fsw_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register bus.
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Report bytes from the USB endpoint.
  input  wire logic        cmd_valid,
  input  wire logic        cmd_first,
  input  wire logic [7:0]  cmd_byte,
  // Response header.
  output logic             resp_valid,
  output logic      [7:0]  resp_cmd,
  output logic      [7:0]  resp_status,
  // Activity sources and indicator enables.
  input  wire logic        rx_busy,
  input  wire logic        tx_busy,
  input  wire logic        twowire_busy,
  input  wire logic        twowire_ind_en,
  input  wire logic        usb_suspended,
  input  wire logic        suspend_ind_en,
  input  wire logic        usb_configured,
  input  wire logic        cfg_ind_en,
  input  wire logic        clkout_en,
  // Indicator and settings outputs.
  output logic             rx_activity_indicator,
  output logic             tx_activity_indicator,
  output logic             twowire_activity_indicator,
  output logic             suspend_indicator,
  output logic             usb_configured_indicator,
  output logic             clock_out,
  output logic             serial_enum_en,
  output logic      [1:0]  security_mode,
  output logic      [1:0]  dac_internal_reference,
  output logic             dac_ref_supply,
  output logic      [4:0]  dac_powerup_value,
  output logic      [31:0] multipurpose_pin_settings
);

  // ****************************************************************
  // Reset release and storage.
  // ****************************************************************
  logic        rst_q1_r;
  logic        rst_n_r;
  fsw_state_t  state_r;
  logic [5:0]  idx_r;
  logic [7:0]  sub_r;
  logic [23:0] chip_r;
  logic [31:0] pin_r;
  logic [63:0] pwd_r;
  logic [7:0]  str_mem_r [FSW_STR_TOTAL];
  logic [7:0]  str_sel_r;
  logic [7:0]  last_status_r;
  logic [4:0]  div_cnt_r;
  logic        data_byte;
  logic        last_byte;
  logic        sub_ok;
  logic        apb_wr;
  logic [7:0]  str_addr;
  logic [31:0] rd_nxt;
  logic        err_nxt;

  // Reset is released through two flops.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_q1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n_r  <= rst_q1_r;
    end
  end

  // ****************************************************************
  // Report parser.
  // ****************************************************************
  assign data_byte = cmd_valid && !cmd_first && (state_r == FSW_ST_DATA);
  assign last_byte = data_byte && (idx_r == FSW_IDX_LAST);
  assign sub_ok    = (sub_r <= FSW_SUB_SER);
  assign str_addr  = 8'((32'(sub_r) - 32'(FSW_SUB_MFR)) * FSW_STR_LEN + 32'(idx_r) - 32'(FSW_IDX_CHIP));

  // State follows the byte position; a first byte always restarts.
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= FSW_ST_IDLE;
      idx_r   <= 6'h00;
      sub_r   <= 8'h00;
    end else if (cmd_valid) begin
      idx_r <= cmd_first ? FSW_IDX_SUB : idx_r + 6'h01;
      if (cmd_first) begin
        state_r <= (cmd_byte == FSW_CMD_WRITE) ? FSW_ST_SUB : FSW_ST_SKIP;
      end else begin
        case (state_r)
          FSW_ST_SUB: begin
            sub_r   <= cmd_byte;
            state_r <= FSW_ST_DATA;
          end
          FSW_ST_DATA, FSW_ST_SKIP: begin
            if (idx_r == FSW_IDX_LAST) begin
              state_r <= FSW_ST_IDLE;
            end
          end
          default: state_r <= FSW_ST_IDLE;
        endcase
      end
    end
  end

  // Response header is issued one cycle after the last report byte.
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      resp_valid    <= 1'b0;
      resp_cmd      <= 8'h00;
      resp_status   <= 8'h00;
      last_status_r <= 8'h00;
    end else begin
      resp_valid <= last_byte;
      if (last_byte) begin
        resp_cmd      <= FSW_CMD_WRITE;
        resp_status   <= sub_ok ? FSW_STAT_OK : FSW_STAT_UNSUP;
        last_status_r <= sub_ok ? FSW_STAT_OK : FSW_STAT_UNSUP;
      end
    end
  end

  // ****************************************************************
  // Settings storage.
  // ****************************************************************
  assign apb_wr = psel && penable && pready && pwrite;

  // Chip settings; report bytes win over a bus write.
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      chip_r <= FSW_CHIP_RST;
    end else if (data_byte && sub_r == FSW_SUB_CHIP) begin
      case (idx_r)
        FSW_IDX_CHIP:   chip_r[7:0]   <= cmd_byte;
        FSW_IDX_CLKDIV: chip_r[15:8]  <= {3'h0, cmd_byte[4:0]};
        FSW_IDX_DAC:    chip_r[23:16] <= cmd_byte;
        default:        chip_r        <= chip_r;
      endcase
    end else if (apb_wr && paddr == FSW_A_CHIP) begin
      chip_r <= {pwdata[23:16], 3'h0, pwdata[12:0]};
    end
  end

  // Password bytes; later bytes of the report are dropped.
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pwd_r <= 64'h0;
    end else if (data_byte && sub_r == FSW_SUB_CHIP && idx_r >= FSW_IDX_PWD_LO && idx_r <= FSW_IDX_PWD_HI) begin
      pwd_r[8*(idx_r - FSW_IDX_PWD_LO) +: 8] <= cmd_byte;
    end
  end

  // Pin power-up settings, payload bytes two to five.
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_r <= FSW_PIN_RST;
    end else if (data_byte && sub_r == FSW_SUB_PIN && idx_r <= FSW_IDX_PIN_HI) begin
      pin_r[8*(idx_r - FSW_IDX_CHIP) +: 8] <= cmd_byte;
    end else if (apb_wr && paddr == FSW_A_PIN) begin
      pin_r <= pwdata;
    end
  end

  // Descriptor strings, one slot per sub-code.
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int i = 0; i < FSW_STR_TOTAL; i++) begin
        str_mem_r[i] <= 8'h00;
      end
    end else if (data_byte && sub_r >= FSW_SUB_MFR && sub_r <= FSW_SUB_SER) begin
      str_mem_r[str_addr] <= cmd_byte;
    end
  end

  // ****************************************************************
  // Indicators and clock output.
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rx_activity_indicator      <= 1'b0;
      tx_activity_indicator      <= 1'b0;
      twowire_activity_indicator <= 1'b0;
      suspend_indicator          <= 1'b0;
      usb_configured_indicator   <= 1'b0;
    end else begin
      rx_activity_indicator      <= chip_r[FSW_B_RX_IDLE] ^ rx_busy;
      tx_activity_indicator      <= chip_r[FSW_B_TX_IDLE] ^ tx_busy;
      twowire_activity_indicator <= chip_r[FSW_B_TW_IDLE] ^ (twowire_ind_en && twowire_busy);
      suspend_indicator          <= chip_r[FSW_B_SP_IDLE] ^ (suspend_ind_en && usb_suspended);
      usb_configured_indicator   <= chip_r[FSW_B_CF_IDLE] ^ (cfg_ind_en && usb_configured);
    end
  end

  // Clock output toggles every divider cycles; zero holds it low.
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      div_cnt_r <= 5'h00;
      clock_out <= 1'b0;
    end else if (!clkout_en || chip_r[FSW_B_DIV_LSB +: 5] == 5'h00) begin
      div_cnt_r <= 5'h00;
      clock_out <= 1'b0;
    end else if (div_cnt_r >= chip_r[FSW_B_DIV_LSB +: 5] - 5'h01) begin
      div_cnt_r <= 5'h00;
      clock_out <= !clock_out;
    end else begin
      div_cnt_r <= div_cnt_r + 5'h01;
    end
  end

  // Settings fields leave straight from the chip and pin settings flops.
  // serial enable
  assign serial_enum_en            = chip_r[FSW_B_SERIAL];
  assign security_mode             = chip_r[1:0];
  assign dac_internal_reference    = chip_r[FSW_B_DREF +: 2];
  assign dac_ref_supply            = chip_r[FSW_B_DAC_SRC];
  assign dac_powerup_value         = chip_r[FSW_B_DAC_LSB +: 5];
  assign multipurpose_pin_settings = pin_r;

  // ****************************************************************
  // Register bus slave, no wait states.
  // ****************************************************************
  always_comb begin
    rd_nxt  = 32'h0;
    err_nxt = 1'b0;
    case (paddr)
      FSW_A_STATUS:   rd_nxt = {16'h0, sub_r, last_status_r};
      FSW_A_CHIP:     rd_nxt = {8'h0, chip_r};
      FSW_A_PIN:      rd_nxt = pin_r;
      FSW_A_PWD_LO:   rd_nxt = pwd_r[31:0];
      FSW_A_PWD_HI:   rd_nxt = pwd_r[63:32];
      FSW_A_STR_SEL:  rd_nxt = {24'h0, str_sel_r};
      FSW_A_STR_DATA: rd_nxt = (str_sel_r < 8'(FSW_STR_TOTAL)) ? {24'h0, str_mem_r[str_sel_r]} : 32'h0;
      default:        err_nxt = 1'b1;
    endcase
  end

  // Answer is prepared in the setup cycle and stands in the access cycle.
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0;
      pslverr <= psel && !penable && err_nxt;
    end
  end

  // String read pointer.
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      str_sel_r <= 8'h00;
    end else if (apb_wr && paddr == FSW_A_STR_SEL) begin
      str_sel_r <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  resp_after_last_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    last_byte |=> resp_valid && resp_cmd == FSW_CMD_WRITE)
    else $error("response header missing after last byte");
  unsup_status_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    last_byte && sub_r > FSW_SUB_SER |=> resp_status == FSW_STAT_UNSUP)
    else $error("unsupported sub-code not reported");
  ok_status_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    last_byte && sub_r <= FSW_SUB_SER |=> resp_status == FSW_STAT_OK)
    else $error("valid sub-code not reported ok");
  unsup_nowrite_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    data_byte && sub_r > FSW_SUB_SER && !apb_wr |=> $stable(chip_r) && $stable(pin_r))
    else $error("settings changed by unsupported sub-code");
  chip_byte_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    data_byte && sub_r == FSW_SUB_CHIP && idx_r == FSW_IDX_CHIP
    |=> security_mode == $past(cmd_byte[1:0]) && serial_enum_en == $past(cmd_byte[7]))
    else $error("chip byte two not stored");
  div_mask_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    chip_r[15:13] == 3'h0)
    else $error("ignored divider bits stored");
  rx_level_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    ##1 rx_activity_indicator == ($past(chip_r[FSW_B_RX_IDLE]) ^ $past(rx_busy)))
    else $error("receive indicator level wrong");
  susp_level_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    !$past(suspend_ind_en) |-> suspend_indicator == $past(chip_r[FSW_B_SP_IDLE]))
    else $error("disabled suspend indicator not idle");
  pready_once_a: assert property (@(posedge clk) disable iff (!rst_n_r)
    psel && penable && pready |=> !pready)
    else $error("ready held beyond one access cycle");
endmodule
`default_nettype wire

// ===== dv/fsw_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Host side: sends one 64-byte report per start pulse.
// ****************************************************************
module fsw_host_model (
  // Clock and control.
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic       slow,
  input  wire logic [7:0] rpt [64],
  // Report byte stream and progress.
  output logic            cmd_valid,
  output logic            cmd_first,
  output logic      [7:0] cmd_byte,
  output logic            busy
);
  // report byte order.
  // Quiet bus first; byte 0 is the code, then sub-code and payload; idle slots show a changing byte.
  initial begin
    cmd_valid = 1'b0;
    cmd_first = 1'b0;
    cmd_byte  = 8'hFF;
    busy      = 1'b0;
    forever begin
      @(posedge clk);
      if (start) begin
        busy <= 1'b1;
        for (int i = 0; i < 64; i++) begin
          if (slow) begin
            cmd_valid <= 1'b0;
            cmd_byte  <= ~cmd_byte;
            @(posedge clk);
          end
          cmd_valid <= 1'b1;
          cmd_first <= (i == 0);
          cmd_byte  <= rpt[i];
          @(posedge clk);
        end
        cmd_valid <= 1'b0;
        cmd_first <= 1'b0;
        cmd_byte  <= ~rpt[63];
        busy      <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb_flash_settings_write.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Self-checking bench for the settings write command.
// ****************************************************************
module tb_flash_settings_write;
  import fsw_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0, slow = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, chip_exp, pin_exp, multipurpose_pin_settings;
  logic [23:0] rv;
  logic        pready, pslverr, err, cmd_valid, cmd_first, resp_valid, host_busy;
  logic [7:0]  cmd_byte, resp_cmd, resp_status;
  logic        rx_busy = 1'b0, tx_busy = 1'b0, twowire_busy = 1'b0, twowire_ind_en = 1'b0;
  logic        usb_suspended = 1'b0, suspend_ind_en = 1'b0, usb_configured = 1'b0, cfg_ind_en = 1'b0;
  logic        clkout_en = 1'b0, rx_activity_indicator, tx_activity_indicator, twowire_activity_indicator;
  logic        suspend_indicator, usb_configured_indicator, clock_out, serial_enum_en, dac_ref_supply;
  logic [1:0]  security_mode, dac_internal_reference;
  logic [4:0]  dac_powerup_value;
  logic [7:0]  rpt [64];
  logic [15:0] expq [$];
  logic [16:0] lfsr = 17'h146A4;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;

  fsw_settings_write i_dut (.clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .cmd_valid, .cmd_first, .cmd_byte, .resp_valid, .resp_cmd, .resp_status, .rx_busy, .tx_busy,
    .twowire_busy, .twowire_ind_en, .usb_suspended, .suspend_ind_en, .usb_configured, .cfg_ind_en,
    .clkout_en, .rx_activity_indicator, .tx_activity_indicator, .twowire_activity_indicator,
    .suspend_indicator, .usb_configured_indicator, .clock_out, .serial_enum_en, .security_mode,
    .dac_internal_reference, .dac_ref_supply, .dac_powerup_value, .multipurpose_pin_settings);
  fsw_host_model i_host (.clk, .start, .slow, .rpt, .cmd_valid, .cmd_first, .cmd_byte, .busy(host_busy));

  // Clock at 40 MHz and a cycle ceiling against hangs.
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // Counts and reports one comparison.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic logic [7:0] rnd();
    for (int i = 0; i < 8; i++) lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return lfsr[7:0];
  endfunction

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // Sends a report with random payload except byte 3 and notes the answer it should draw.
  task automatic send(input logic [7:0] c, input logic [7:0] s, input logic sl, input logic [7:0] b3);
    rpt[0] = c;
    rpt[1] = s;
    for (int i = 2; i < 64; i++) rpt[i] = rnd();
    rpt[3] = b3;
    if (c == FSW_CMD_WRITE) expq.push_back({FSW_CMD_WRITE, (s > FSW_SUB_SER) ? FSW_STAT_UNSUP : FSW_STAT_OK});
    slow  <= sl;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do begin
      @(posedge clk);
    end while (host_busy !== 1'b0);
    repeat (3) @(posedge clk);
  endtask

  task automatic chip_chk();
    rdc("chip", FSW_A_CHIP, chip_exp);
    chk("ser_en", chip_exp[7], serial_enum_en);
    chk("sec", chip_exp[1:0], security_mode);
    chk("dref", chip_exp[23:22], dac_internal_reference);
    chk("dsup", chip_exp[21], dac_ref_supply);
    chk("dval", chip_exp[20:16], dac_powerup_value);
  endtask

  // Random activity and enables; indicators follow one cycle later.
  task automatic ind_chk();
    logic [7:0] v;
    for (int k = 0; k < 12; k++) begin
      v = rnd();
      {cfg_ind_en, usb_configured, suspend_ind_en, usb_suspended} <= v[7:4];
      {twowire_ind_en, twowire_busy, tx_busy, rx_busy} <= v[3:0];
      repeat (2) @(posedge clk);
      chk("rx_ind", chip_exp[6] ^ v[0], rx_activity_indicator);
      chk("tx_ind", chip_exp[5] ^ v[1], tx_activity_indicator);
      chk("tw_ind", chip_exp[4] ^ (v[2] & v[3]), twowire_activity_indicator);
      chk("sp_ind", chip_exp[3] ^ (v[4] & v[5]), suspend_indicator);
      chk("cf_ind", chip_exp[2] ^ (v[6] & v[7]), usb_configured_indicator);
    end
  endtask

  // Cycles between two changes of the clock output.
  task automatic clk_chk(input int d);
    int n;
    logic p;
    @(posedge clk);
    p = clock_out;
    for (n = 0; n < 200 && clock_out === p; n++) @(posedge clk);
    p = clock_out;
    for (n = 0; n < 200 && clock_out === p; n++) @(posedge clk);
    chk("ck_half", d, n);
  endtask

  // Each response pulse is matched against the oldest note.
  always @(posedge clk) begin
    if (resp_valid === 1'b1) begin
      if (expq.size() == 0) chk("resp_unexp", 32'h0, 32'h1);
      else chk("resp", {16'h0, expq.pop_front()}, {16'h0, resp_cmd, resp_status});
    end
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chip_exp = {8'h00, FSW_CHIP_RST};
    chip_chk();
    rdc("pin_rst", FSW_A_PIN, FSW_PIN_RST);
    $display("reset test done");
    send(FSW_CMD_WRITE, FSW_SUB_CHIP, 1'b1, rnd());
    chip_exp = {8'h00, rpt[4], 3'b000, rpt[3][4:0], rpt[2]};
    chip_chk();
    rdc("pwd_lo", FSW_A_PWD_LO, {rpt[15], rpt[14], rpt[13], rpt[12]});
    rdc("pwd_hi", FSW_A_PWD_HI, {rpt[19], rpt[18], rpt[17], rpt[16]});
    ind_chk();
    send(FSW_CMD_WRITE, FSW_SUB_CHIP, 1'b0, 8'hE3);
    chip_exp = {8'h00, rpt[4], 16'h0300 | rpt[2]};
    chip_chk();
    clkout_en <= 1'b1;
    clk_chk(3);
    clkout_en <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ck_off", 1'b0, clock_out);
    $display("chip report test done");
    for (int m = 0; m < 4; m++) begin
      rv = {rnd(), rnd(), rnd()};
      chip_exp = {8'h00, 2'(m), rv[21:16], 3'b000, rv[12:8], rv[7:2], 2'(m)};
      apb(1'b1, FSW_A_CHIP, chip_exp | 32'hFF00E000);
      chip_chk();
    end
    ind_chk();
    $display("mode test done");
    send(FSW_CMD_WRITE, FSW_SUB_PIN, 1'b0, rnd());
    pin_exp = {rpt[5], rpt[4], rpt[3], rpt[2]};
    chk("pin", pin_exp, multipurpose_pin_settings);
    rdc("pin_reg", FSW_A_PIN, pin_exp);
    for (int s = 2; s < 5; s++) begin
      send(FSW_CMD_WRITE, 8'(s), 1'b1, rnd());
      for (int k = 2; k < 64; k += 61) begin
        apb(1'b1, FSW_A_STR_SEL, 32'((s - 2) * 62 + k - 2));
        rdc("str", FSW_A_STR_DATA, {24'h0, rpt[k]});
      end
      rdc("stat", FSW_A_STATUS, {16'h0, 8'(s), FSW_STAT_OK});
    end
    chip_chk();
    $display("pin and string test done");
    send(FSW_CMD_WRITE, 8'h05, 1'b0, rnd());
    send(FSW_CMD_WRITE, 8'hFF, 1'b0, rnd());
    chip_chk();
    chk("pin_keep", pin_exp, multipurpose_pin_settings);
    send(8'h4E, FSW_SUB_CHIP, 1'b0, rnd());
    chip_chk();
    apb(1'b1, FSW_A_STATUS, 32'h0000_1234);
    rdc("stat_ro", FSW_A_STATUS, {16'h0, 8'hFF, FSW_STAT_UNSUP});
    rdc("unmapped", 8'h40, 32'h0);
    chk("slverr", 1'b1, err);
    $display("refusal test done");
    chk("queue", 32'h0, expq.size());
    stop_test();
  end
endmodule
`default_nettype wire
